// ==== rtl/gearing_pkg.sv ====
// Purpose: shared constants and types for electronic gearing and current limit
// Assumes: 125 MHz ref_clk; master and step inputs already synchronous
// Notes:   current values are signed fixed point amperes, scale set by user
package gearing_pkg;

    // ------------------------------------------------------------
    // follow modes and loop selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FOLLOW_OFF = 2'b00,
        FOLLOW_BI  = 2'b01,
        FOLLOW_CW  = 2'b10,
        FOLLOW_CCW = 2'b11
    } follow_e;

    localparam logic [1:0] LOOP_POSITION = 2'h2;
    localparam logic RATIO_FROM_LINES = 1'b0;
    localparam logic RATIO_FROM_PULSES = 1'b1;

    // ------------------------------------------------------------
    // widths and fixed-point layout
    // ------------------------------------------------------------
    localparam int POS_W = 32;
    localparam int ACC_W = 42;
    localparam int RATIO_FRAC = 8;   // ratio value is unsigned 8.8
    localparam int QUAD_PER_LINE_SHIFT = 2;

    // ------------------------------------------------------------
    // current limit
    // ------------------------------------------------------------
    localparam int CUR_W = 16;
    localparam int PCT_W = 7;
    localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;   // 100 percent
    localparam logic [PCT_W-1:0] LIMIT_RESET = 7'h64;

endpackage : gearing_pkg

// ==== rtl/torque_if.sv ====
// Purpose: carries torque request and limit settings to the limiter
// Assumes: single ref_clk domain
// Notes:   positive current is clockwise
`timescale 1ns/1ns
interface torque_if;
    logic signed [gearing_pkg::CUR_W-1:0] request;
    logic [gearing_pkg::CUR_W-1:0] peak;
    logic limitLoad;
    logic [gearing_pkg::PCT_W-1:0] cwLimitIn;
    logic [gearing_pkg::PCT_W-1:0] ccwLimitIn;
    logic signed [gearing_pkg::CUR_W-1:0] command;
    logic clipped;
    logic [gearing_pkg::PCT_W-1:0] cwLimit;
    logic [gearing_pkg::PCT_W-1:0] ccwLimit;

    modport source (output request, peak, limitLoad, cwLimitIn, ccwLimitIn,
                    input command, clipped, cwLimit, ccwLimit);
    modport limiter (input request, peak, limitLoad, cwLimitIn, ccwLimitIn,
                     output command, clipped, cwLimit, ccwLimit);
endinterface : torque_if

// ==== rtl/current_limiter.sv ====
// Purpose: directional torque current limit as percent of peak rating
// Assumes: request and peak share the same ampere scale
// Notes:   one cycle from request to saturated command
`timescale 1ns/1ns
module current_limiter (
    input wire logic ref_clk,
    input wire logic rst,
    torque_if.limiter tq
);
    localparam int PROD_W = gearing_pkg::CUR_W + gearing_pkg::PCT_W;

    logic [gearing_pkg::PCT_W-1:0] next_cw;
    logic [gearing_pkg::PCT_W-1:0] next_ccw;
    logic signed [gearing_pkg::CUR_W-1:0] next_command;
    logic next_clipped;
    logic [gearing_pkg::CUR_W-1:0] cwBound;
    logic [gearing_pkg::CUR_W-1:0] ccwBound;

    // clamp a percent setting to the legal 0..100 span
    function automatic logic [gearing_pkg::PCT_W-1:0] clampPct(
        input logic [gearing_pkg::PCT_W-1:0] p);
        clampPct = (p > gearing_pkg::PCT_FULL) ? gearing_pkg::PCT_FULL : p;
    endfunction : clampPct

    // peak times percent over 100; truncation keeps bound under the limit
    function automatic logic [gearing_pkg::CUR_W-1:0] bound(
        input logic [gearing_pkg::CUR_W-1:0] pk,
        input logic [gearing_pkg::PCT_W-1:0] pct);
        logic [PROD_W-1:0] prod;
        prod = PROD_W'(pk) * PROD_W'(pct);
        bound = gearing_pkg::CUR_W'(prod / PROD_W'(gearing_pkg::PCT_FULL));
    endfunction : bound

    assign cwBound = bound(tq.peak, tq.cwLimit);
    assign ccwBound = bound(tq.peak, tq.ccwLimit);

    // ------------------------------------------------------------
    // limit settings and saturation
    // ------------------------------------------------------------
    // whole percents only: the port has no fraction bits
    always_comb begin
        next_cw = tq.cwLimit;
        next_ccw = tq.ccwLimit;
        if (tq.limitLoad) begin
            next_cw = clampPct(tq.cwLimitIn); // R18
            next_ccw = clampPct(tq.ccwLimitIn); // R17 R19
        end
        next_command = tq.request;
        next_clipped = 1'b0;
        if (!tq.request[gearing_pkg::CUR_W-1] &&
            $unsigned(tq.request) > cwBound) begin
            next_command = $signed(cwBound); // R20 R16
            next_clipped = 1'b1;
        end else if (tq.request[gearing_pkg::CUR_W-1] &&
                     $unsigned(-tq.request) > ccwBound) begin
            next_command = -$signed(ccwBound); // R20 R16
            next_clipped = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tq.cwLimit <= gearing_pkg::LIMIT_RESET;
            tq.ccwLimit <= gearing_pkg::LIMIT_RESET;
            tq.command <= '0;
            tq.clipped <= 1'b0;
        end else begin
            tq.cwLimit <= next_cw;
            tq.ccwLimit <= next_ccw;
            tq.command <= next_command;
            tq.clipped <= next_clipped;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_cw_bound: assert property (@(posedge ref_clk) disable iff (rst) // R18
        !tq.command[gearing_pkg::CUR_W-1] |->
        $unsigned(tq.command) <= $past(cwBound))
        else $error("clockwise command above its bound");
    a_ccw_bound: assert property (@(posedge ref_clk) disable iff (rst) // R17
        tq.command[gearing_pkg::CUR_W-1] |->
        $unsigned(-tq.command) <= $past(ccwBound))
        else $error("counter-clockwise command above its bound");
    a_limit_default: assert property (@(posedge ref_clk) // R19
        $fell(rst) |-> tq.ccwLimit == 7'h64 && tq.cwLimit == 7'h64)
        else $error("limits not at full scale after reset");
    a_pass_within: assert property (@(posedge ref_clk) disable iff (rst) // R16
        !next_clipped |=> tq.command == $past(tq.request) && !tq.clipped)
        else $error("unclipped request altered");

endmodule : current_limiter

// ==== rtl/electronic_gearing.sv ====
// Purpose: electronic gearing from master encoder or step/direction input
// Assumes: all inputs synchronous to ref_clk, at most one master edge a cycle
// Notes:   ratio settings are read live; positive motion is clockwise
//
// Contract
// [R1] mode 1 follows master motion in both directions
// [R2] mode 2 follows only clockwise master motion
// [R3] mode 3 follows only counterclockwise master motion
// [R4] mode 0 does no following at all
// [R5] following only while loop type selects position loop
// [R6] line count is encoder lines or steps per revolution
// [R7] emulated encoder output at programmed resolution
// [R8] ratio source 0 uses line count and ratio, 1 uses pulse counts
// [R9] pulse mode moves output count units per input count pulses
// [R10] line mode ratio scales master shaft to motor shaft movement
// [R11] host programs steps per rev over 4 for step input
// [R12] host writes setup parameters in order before enabling
// [R13] ratio changes take effect while following is active
// [R14] single direction resumes only past the reversal point
// [R15] accumulated master position is readable
// [R16] command bounded by peak times directional percent over 100
// [R17] ccw current limited to 0..100 percent of peak
// [R18] cw current limited to percent of peak
// [R19] ccw limit whole percent, defaults to 100
// [R20] command saturated at the directional limit
`timescale 1ns/1ns
module electronic_gearing #(
    parameter int CNT_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] loop_type_select,
    input wire logic [1:0] follow_mode_select,
    input wire logic step_direction_select,
    input wire logic ratio_source_select,
    input wire logic [CNT_W-1:0] master_line_count,
    input wire logic [CNT_W-1:0] ratio_value,
    input wire logic [CNT_W-1:0] emulated_output_resolution,
    input wire logic [CNT_W-1:0] input_pulse_count,
    input wire logic [CNT_W-1:0] output_pulse_count,
    input wire logic masterA,
    input wire logic masterB,
    input wire logic stepIn,
    input wire logic dirIn,
    output logic [gearing_pkg::POS_W-1:0] master_position_count,
    output logic [gearing_pkg::POS_W-1:0] motorPosition,
    output logic motorStep,
    output logic motorDir,
    output logic emuA,
    output logic emuB,
    input wire logic signed [gearing_pkg::CUR_W-1:0] torqueRequest,
    input wire logic [gearing_pkg::CUR_W-1:0] peak_current_rating,
    input wire logic limitLoad,
    input wire logic [gearing_pkg::PCT_W-1:0] cwLimitIn,
    input wire logic [gearing_pkg::PCT_W-1:0] ccwLimitIn,
    output logic [gearing_pkg::PCT_W-1:0] cw_current_limit,
    output logic [gearing_pkg::PCT_W-1:0] ccw_current_limit,
    output logic signed [gearing_pkg::CUR_W-1:0] commanded_torque_current,
    output logic currentClipped
);
    localparam int POS_W = gearing_pkg::POS_W;
    localparam int ACC_W = gearing_pkg::ACC_W;

    gearing_pkg::follow_e mode;
    logic active;
    logic prevA;
    logic prevB;
    logic prevStep;
    logic signed [1:0] masterDelta;
    logic signed [1:0] passDelta;
    logic [POS_W-1:0] refPos;
    logic signed [ACC_W-1:0] acc;
    logic [ACC_W-1:0] num;
    logic [ACC_W-1:0] den;
    logic [POS_W-1:0] next_masterPos;
    logic [POS_W-1:0] next_refPos;
    logic signed [ACC_W-1:0] next_acc;
    logic signed [ACC_W-1:0] sumAcc;
    logic [POS_W-1:0] next_motorPos;
    logic next_step;
    logic next_dir;

    assign mode = gearing_pkg::follow_e'(follow_mode_select);
    assign active = (loop_type_select == gearing_pkg::LOOP_POSITION) // R5
        && (mode != gearing_pkg::FOLLOW_OFF); // R4

    // quadrature transition to signed count, clockwise leads on B
    function automatic logic signed [1:0] quadStep(
        input logic [1:0] was, input logic [1:0] now);
        logic [3:0] t;
        t = {was, now};
        unique case (t)
            4'h1, 4'h7, 4'hE, 4'h8: quadStep = 2'sb01;
            4'h2, 4'hB, 4'hD, 4'h4: quadStep = 2'sb11;
            default: quadStep = 2'sb00;  // no move or illegal double step
        endcase
    endfunction : quadStep

    // ------------------------------------------------------------
    // master input decode
    // ------------------------------------------------------------
    // step input counts on the rising edge, direction high is clockwise
    always_comb begin
        if (step_direction_select) begin
            masterDelta = (stepIn && !prevStep) ?
                (dirIn ? 2'sb01 : 2'sb11) : 2'sb00;
        end else begin
            masterDelta = quadStep({prevA, prevB}, {masterA, masterB});
        end
    end

    // ------------------------------------------------------------
    // direction filter with reversal memory
    // ------------------------------------------------------------
    // refPos holds the furthest point reached in the allowed direction
    always_comb begin
        next_masterPos = master_position_count
            + POS_W'(signed'(masterDelta)); // R15
        next_refPos = refPos;
        passDelta = 2'sb00;
        if (!active) begin
            next_refPos = next_masterPos;
        end else begin
            unique case (mode)
                gearing_pkg::FOLLOW_BI: begin
                    passDelta = masterDelta; // R1
                    next_refPos = next_masterPos;
                end
                gearing_pkg::FOLLOW_CW: begin
                    if (masterDelta == 2'sb01 &&
                        $signed(master_position_count - refPos) >= 0) begin
                        passDelta = 2'sb01; // R2 R14
                        next_refPos = next_masterPos;
                    end
                end
                gearing_pkg::FOLLOW_CCW: begin
                    if (masterDelta == 2'sb11 &&
                        $signed(master_position_count - refPos) <= 0) begin
                        passDelta = 2'sb11; // R3 R14
                        next_refPos = next_masterPos;
                    end
                end
                gearing_pkg::FOLLOW_OFF: passDelta = 2'sb00; // R4
            endcase
        end
    end

    // ------------------------------------------------------------
    // ratio engine
    // ------------------------------------------------------------
    // motor counts per master count = num / den; settings read live so a
    // new ratio applies on the next master count, at the cost of no
    // double buffering against a half-written ratio
    always_comb begin
        if (ratio_source_select == gearing_pkg::RATIO_FROM_PULSES) begin
            num = ACC_W'(output_pulse_count); // R8 R9
            den = ACC_W'(input_pulse_count); // R9
        end else begin
            num = ACC_W'(ratio_value) * ACC_W'(emulated_output_resolution); // R10 R7
            den = ACC_W'(master_line_count) << gearing_pkg::RATIO_FRAC; // R6 R10
        end
    end

    // one motor step per cycle at most; the remainder stays in acc
    always_comb begin
        sumAcc = acc;
        if (passDelta == 2'sb01) begin
            sumAcc = acc + $signed(num); // R13
        end else if (passDelta == 2'sb11) begin
            sumAcc = acc - $signed(num); // R13
        end
        next_acc = sumAcc;
        next_step = 1'b0;
        next_dir = motorDir;
        next_motorPos = motorPosition;
        if (!active || den == '0) begin
            next_acc = '0;
        end else if (sumAcc >= $signed(den)) begin
            next_acc = sumAcc - $signed(den); // R9
            next_step = 1'b1;
            next_dir = 1'b1;
            next_motorPos = motorPosition + 1'b1;
        end else if (sumAcc <= -$signed(den)) begin
            next_acc = sumAcc + $signed(den); // R9
            next_step = 1'b1;
            next_dir = 1'b0;
            next_motorPos = motorPosition - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    // emulated quadrature is the gray code of the motor count low bits
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prevA <= 1'b0;
            prevB <= 1'b0;
            prevStep <= 1'b0;
            master_position_count <= '0;
            refPos <= '0;
            acc <= '0;
            motorPosition <= '0;
            motorStep <= 1'b0;
            motorDir <= 1'b0;
            emuA <= 1'b0;
            emuB <= 1'b0;
        end else begin
            prevA <= masterA;
            prevB <= masterB;
            prevStep <= stepIn;
            master_position_count <= next_masterPos; // R15
            refPos <= next_refPos;
            acc <= next_acc;
            motorPosition <= next_motorPos;
            motorStep <= next_step;
            motorDir <= next_dir;
            emuA <= next_motorPos[1]; // R7
            emuB <= next_motorPos[1] ^ next_motorPos[0]; // R7
        end
    end

    // ------------------------------------------------------------
    // current limit
    // ------------------------------------------------------------
    torque_if tq ();
    assign tq.request = torqueRequest;
    assign tq.peak = peak_current_rating;
    assign tq.limitLoad = limitLoad;
    assign tq.cwLimitIn = cwLimitIn;
    assign tq.ccwLimitIn = ccwLimitIn;
    assign commanded_torque_current = tq.command;
    assign currentClipped = tq.clipped;
    assign cw_current_limit = tq.cwLimit;
    assign ccw_current_limit = tq.ccwLimit;

    current_limiter limiter (
        .ref_clk(ref_clk),
        .rst(rst),
        .tq(tq)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_fwd_master;
        active && mode == gearing_pkg::FOLLOW_BI && masterDelta == 2'sb01;
    endsequence
    sequence s_cw_behind;
        active && mode == gearing_pkg::FOLLOW_CW && masterDelta == 2'sb01
            && $signed(master_position_count - refPos) < 0;
    endsequence
    sequence s_ccw_behind;
        active && mode == gearing_pkg::FOLLOW_CCW && masterDelta == 2'sb11
            && $signed(master_position_count - refPos) > 0;
    endsequence

    a_bidir_follow: assert property (s_fwd_master |-> passDelta == 2'sb01) // R1
        else $error("bidirectional mode dropped a master count");
    a_cw_only: assert property ( // R2
        mode == gearing_pkg::FOLLOW_CW |-> passDelta != 2'sb11)
        else $error("clockwise mode passed a reverse count");
    a_ccw_only: assert property ( // R3
        mode == gearing_pkg::FOLLOW_CCW |-> passDelta != 2'sb01)
        else $error("counterclockwise mode passed a forward count");
    a_off_idle: assert property ( // R4
        mode == gearing_pkg::FOLLOW_OFF |=> !motorStep && acc == '0)
        else $error("motor stepped with following off");
    a_loop_gate: assert property ( // R5
        loop_type_select != gearing_pkg::LOOP_POSITION |=> !motorStep)
        else $error("motor stepped outside position loop");
    a_reversal_hold: assert property (s_cw_behind |-> passDelta == 2'sb00) // R14
        else $error("resumed before reaching reversal point");
    a_master_count: assert property ( // R15
        masterDelta == 2'sb01 |=>
        master_position_count == $past(master_position_count) + 1'b1)
        else $error("master position did not advance");
    a_pulse_step: assert property ( // R9
        active && ratio_source_select && input_pulse_count != '0 &&
        next_step |=> motorStep ##1 acc < $signed(ACC_W'(input_pulse_count))
            || !active || passDelta != 2'sb00 || motorStep)
        else $error("pulse ratio step left remainder over divisor");

    // the mirror of the clockwise reversal hold
    a_ccw_reversal: assert property ( // R14
        s_ccw_behind |-> passDelta == 2'sb00)
        else $error("ccw mode resumed before reversal point");

    a_bidir_reverse: assert property ( // R1
        active && mode == gearing_pkg::FOLLOW_BI && masterDelta == 2'sb11
        |-> passDelta == 2'sb11)
        else $error("bidirectional mode dropped a reverse count");

    // a lost or doubled step would let the count drift from the pulses
    a_step_moves: assert property ( // R9
        motorStep |-> motorPosition == $past(motorPosition)
            + (motorDir ? 32'h00000001 : 32'hFFFFFFFF))
        else $error("motor count and step pulse disagree");

endmodule : electronic_gearing

// ==== tb/master_source.sv ====
// Purpose: master encoder or step and direction source for the gearing block
// Assumes: one count per call step, spaced two or more clocks apart
// Notes:   quadrature phase 00-01-11-10 counts clockwise
`timescale 1ns/1ns
module master_source (
    input wire logic ref_clk,
    input wire logic stepMode,
    output logic masterA,
    output logic masterB,
    output logic stepIn,
    output logic dirIn
);
    logic [1:0] phase;

    // encoder and step lines start low, as a stopped encoder would leave them; dirIn starts high
    initial begin
        phase = 2'h0;
        masterA = 1'b0;
        masterB = 1'b0;
        stepIn = 1'b0;
        dirIn = 1'b1;
    end

    // ------------------------------------------------------------
    // one master count per loop, never two in one cycle
    // ------------------------------------------------------------
    task automatic move(input int n, input logic cw);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            if (stepMode) begin
                dirIn <= cw; // dir set a cycle ahead of the step
                @(posedge ref_clk);
                stepIn <= 1'b1;
                @(posedge ref_clk);
                stepIn <= 1'b0;
            end else begin
                phase = cw ? phase + 2'h1 : phase - 2'h1;
                masterA <= phase[1];
                masterB <= phase[1] ^ phase[0];
                @(posedge ref_clk);
            end
        end
    endtask : move
endmodule : master_source

// ==== tb/electronic_gearing_tb.sv ====
// Purpose: self-checking bench for gearing and current limit
// Assumes: 125 MHz ref_clk, fixed settle waits after each master burst
// Notes:   expected positions are tracked here from the stimulus alone
`timescale 1ns/1ns
module electronic_gearing_tb;
    logic ref_clk, rst, stepSel, ratioSrc, limitLoad;
    logic [1:0] loopType, followMode;
    logic [15:0] lineCnt, ratioVal, emuRes, pinCnt, poutCnt, peak;
    logic signed [15:0] torqueReq, cmdOut;
    logic [6:0] cwIn, ccwIn, cwLim, ccwLim;
    logic [31:0] masterPos, motorPos, expMaster, expMotor;
    logic mA, mB, sIn, dIn, emuA, emuB, clipped, mStep, mDir;
    int testsRun = 0;
    int miscompares = 0;
    int steps = 0;

    electronic_gearing dut (
        .ref_clk(ref_clk), .rst(rst), .loop_type_select(loopType),
        .follow_mode_select(followMode), .step_direction_select(stepSel),
        .ratio_source_select(ratioSrc), .master_line_count(lineCnt),
        .ratio_value(ratioVal), .emulated_output_resolution(emuRes),
        .input_pulse_count(pinCnt), .output_pulse_count(poutCnt),
        .masterA(mA), .masterB(mB), .stepIn(sIn), .dirIn(dIn),
        .master_position_count(masterPos), .motorPosition(motorPos),
        .motorStep(mStep), .motorDir(mDir), .emuA(emuA), .emuB(emuB),
        .torqueRequest(torqueReq), .peak_current_rating(peak),
        .limitLoad(limitLoad), .cwLimitIn(cwIn), .ccwLimitIn(ccwIn),
        .cw_current_limit(cwLim), .ccw_current_limit(ccwLim),
        .commanded_torque_current(cmdOut), .currentClipped(clipped)
    );

    master_source src (
        .ref_clk(ref_clk), .stepMode(stepSel), .masterA(mA),
        .masterB(mB), .stepIn(sIn), .dirIn(dIn)
    );

    // 8 ns period
    always #4 ref_clk = ~ref_clk;

    // step pulses seen, judged in go
    always @(posedge ref_clk) if (mStep === 1'b1) steps <= steps + 1;

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize

    // host writes in the documented order, following switched on last
    task automatic setup(input logic [1:0] lt, input logic sd, rs,
            input logic [15:0] emu, ln, rt, pi, po, input logic [1:0] md);
        @(posedge ref_clk) followMode <= 2'h0;
        @(posedge ref_clk) loopType <= lt;
        @(posedge ref_clk) stepSel <= sd;
        @(posedge ref_clk) ratioSrc <= rs;
        @(posedge ref_clk) emuRes <= emu;
        @(posedge ref_clk) lineCnt <= ln;
        @(posedge ref_clk) ratioVal <= rt;
        @(posedge ref_clk) pinCnt <= pi;
        @(posedge ref_clk) poutCnt <= po;
        @(posedge ref_clk) followMode <= md;
    endtask : setup

    // burst of master counts, then positions and emulated phase judged
    task automatic go(input int n, input logic cw, input int dm);
        int s0 = steps;
        src.move(n, cw);
        repeat (10) @(posedge ref_clk);
        #1;
        expMaster = cw ? expMaster + 32'(n) : expMaster - 32'(n);
        expMotor = expMotor + 32'(dm);
        check(masterPos, expMaster);
        check(motorPos, expMotor);
        check({30'h0, emuA, emuB},
              {30'h0, expMotor[1], expMotor[1] ^ expMotor[0]});
        check(32'(steps - s0), 32'(dm < 0 ? -dm : dm));
        if (dm != 0) check(32'(mDir), 32'(dm > 0));
    endtask : go

    task automatic torque(input logic [15:0] rq, ex, input logic cl);
        @(posedge ref_clk) torqueReq <= rq;
        repeat (2) @(posedge ref_clk);
        #1;
        check({16'h0000, cmdOut}, {16'h0000, ex});
        check({31'h0, clipped}, {31'h0, cl});
    endtask : torque

    task automatic limits(input logic [6:0] cw, ccw);
        @(posedge ref_clk) limitLoad <= 1'b1;
        cwIn <= cw;
        ccwIn <= ccw;
        @(posedge ref_clk) limitLoad <= 1'b0;
        @(posedge ref_clk);
    endtask : limits

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check({25'h0, ccwLim}, 32'h00000064);
        check({25'h0, cwLim}, 32'h00000064);
        check(masterPos, 32'h00000000);
        check({16'h0000, cmdOut}, 32'h00000000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_current();
        @(posedge ref_clk) peak <= 16'h03E8;
        limits(7'h28, 7'h7F);
        #1;
        check({25'h0, cwLim}, 32'h00000028);
        check({25'h0, ccwLim}, 32'h00000064);
        torque(16'h01F4, 16'h0190, 1'b1);
        torque(16'hF830, 16'hFC18, 1'b1);
        limits(7'h28, 7'h1E);
        torque(16'hFE0C, 16'hFED4, 1'b1);
        torque(16'h00C8, 16'h00C8, 1'b0);
        limits(7'h00, 7'h64);
        torque(16'h0001, 16'h0000, 1'b1);
        $display("test current limit done");
    endtask : t_current

    task automatic t_bidir();
        setup(2'h2, 1'b0, 1'b1, 16'h0004, 16'h0004, 16'h0100,
              16'h0002, 16'h0001, 2'h1);
        go(4, 1'b1, 2);
        go(4, 1'b0, -2);
        $display("test bidirectional done");
    endtask : t_bidir

    task automatic t_off();
        @(posedge ref_clk) followMode <= 2'h0;
        go(4, 1'b1, 0);
        @(posedge ref_clk) loopType <= 2'h1;
        followMode <= 2'h1;
        go(4, 1'b1, 0);
        $display("test following off done");
    endtask : t_off

    task automatic t_single();
        setup(2'h2, 1'b0, 1'b1, 16'h0004, 16'h0004, 16'h0100,
              16'h0001, 16'h0001, 2'h2);
        go(3, 1'b1, 3);
        go(2, 1'b0, 0);
        go(4, 1'b1, 2);
        @(posedge ref_clk) followMode <= 2'h0;
        @(posedge ref_clk) followMode <= 2'h3;
        go(3, 1'b0, -3);
        go(2, 1'b1, 0);
        go(4, 1'b0, -2);
        $display("test single direction done");
    endtask : t_single

    task automatic t_ratio_change();
        @(posedge ref_clk) followMode <= 2'h1;
        go(2, 1'b1, 2);
        @(posedge ref_clk) poutCnt <= 16'h0002;
        go(2, 1'b1, 4);
        $display("test live ratio change done");
    endtask : t_ratio_change

    task automatic t_line();
        setup(2'h2, 1'b0, 1'b0, 16'h0004, 16'h0004, 16'h0080,
              16'h0001, 16'h0001, 2'h1);
        go(4, 1'b1, 2);
        setup(2'h2, 1'b0, 1'b0, 16'h0008, 16'h0004, 16'h0100,
              16'h0001, 16'h0001, 2'h1);
        go(2, 1'b1, 4);
        $display("test line count ratio done");
    endtask : t_line

    task automatic t_step();
        // 16 steps per rev programmed as 16 / 4
        setup(2'h2, 1'b1, 1'b0, 16'h0004, 16'h0004, 16'h0100,
              16'h0001, 16'h0001, 2'h1);
        go(3, 1'b1, 3);
        go(1, 1'b0, -1);
        $display("test step and direction done");
    endtask : t_step

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        {stepSel, ratioSrc, limitLoad} = 3'h0;
        {loopType, followMode} = 4'h0;
        {lineCnt, ratioVal, emuRes} = 48'h0;
        {pinCnt, poutCnt, peak, torqueReq} = 64'h0;
        {cwIn, ccwIn} = 14'h0;
        expMaster = 32'h0;
        expMotor = 32'h0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        t_reset();
        t_current();
        t_bidir();
        t_off();
        t_single();
        t_ratio_change();
        t_line();
        t_step();
        summarize();
    end

    // a hang counts as a mismatch and closes the run
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        summarize();
    end
endmodule : electronic_gearing_tb
